// >>> rtpp_bc_model.sv
// Message source standing in for the bus controller side of the core.
`timescale 1ns/10ps
module rtpp_bc_model (
  input  wire       hclk,
  input  wire       store_enable,
  input  wire       use_second_pointer,
  output reg        msg_done,
  output reg        msg_error,
  output reg        msg_illegal,
  output reg        msg_broadcast,
  output reg  [4:0] msg_rt_addr
);
  reg stored;
  reg second;
  initial {msg_done, msg_error, msg_illegal, msg_broadcast, msg_rt_addr} = 9'h000;
  // Each message is held two cycles so the core's idle phase sees it once.
  task send(input e, input il, input b, input [4:0] a);
    integer i;
    begin
      stored = 1'b0;
      second = 1'b0;
      {msg_done, msg_error, msg_illegal, msg_broadcast, msg_rt_addr} <= {1'b1, e, il, b, a};
      for (i = 0; i < 8; i = i + 1)
      begin
        @(posedge hclk);
        if (i == 1)
        begin
          msg_done <= 1'b0;
          {msg_error, msg_illegal, msg_broadcast, msg_rt_addr} <= ~{e, il, b, a};
        end
        if (store_enable === 1'b1)
        begin
          stored = 1'b1;
          second = use_second_pointer;
        end
      end
    end
  endtask
endmodule // rtpp_bc_model

// >>> rtpp_core.v
// Receive subaddress ping-pong status logic with an AHB-Lite register slave.
// Behaviour
// R1 - Keep read-only next buffer selector bit
// R2 - Selector 0 uses first pointer, 1 second
// R3 - Toggle selector after each error-free message
// R4 - Host should set hold-pointer-on-failure option
// R5 - Master and soft reset clear selector
// R6 - Selector ignored outside ping-pong mode
// R7 - Set broadcast flag on valid broadcast receive
// R8 - Interrupt on broadcast when both enables set
// R9 - Broadcast disable makes address 31 invalid
// R10 - Master and soft reset clear broadcast flag
// R11 - Host writes never change acknowledge bit
// R12 - Acknowledge meaningful only with ping-pong enable
// R13 - Assert acknowledge once ping-pong is active
// R14 - Stop request makes device clear acknowledge
// R15 - Host unloads buffer only while acknowledge low
// R16 - Clearing stop request re-asserts acknowledge
// R17 - Enabled but unacknowledged: overwrite, no toggle
// R18 - Forced busy: no store, selector unchanged
// R19 - Update status bits in one write-back
`timescale 1ns/10ps
`include "rtpp_regs.vh"
module rtpp_core #(
  parameter MODE_W = 2
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        master_reset_pin,
  input  wire        msg_done,
  input  wire        msg_error,
  input  wire        msg_illegal,
  input  wire        msg_broadcast,
  input  wire [4:0]  msg_rt_addr,
  output reg         store_enable,
  output reg         use_second_pointer,
  output reg         irq
);
  localparam MODE_PINGPONG = 2'h1;
  localparam S_IDLE = 2'h0;
  localparam S_WB   = 2'h1;

  wire        mr_sync;
  reg         mr_d;
  reg  [31:0] ctrl;
  reg  [15:0] desc;
  reg  [`RTPP_IRQ_WIDTH-1:0] irq_status;
  reg  [`RTPP_IRQ_WIDTH-1:0] irq_mask;
  reg  [1:0]  state;
  reg         wr_pend;
  reg  [11:0] wr_addr;
  reg         pend_sel;
  reg         pend_broadcast_received_flag;
  reg         pend_ack;
  reg  [`RTPP_IRQ_WIDTH-1:0] next_events;
  reg  [`RTPP_IRQ_WIDTH-1:0] next_irq_status;
  reg  [`RTPP_IRQ_WIDTH-1:0] next_irq_mask;
  reg  [31:0] next_ctrl;
  reg  [15:0] next_desc;
  reg         next_sel;
  reg         next_broadcast_received_flag;
  reg         next_ack;
  wire        soft_reset_cmd;
  wire        broadcast_disable;
  wire        hold_pointer_on_failure;
  wire        pingpong_enable;
  wire        pingpong_stop_request;
  wire        force_busy_response;
  wire        broadcast_irq_select;
  wire        pingpong_mode;
  wire        msg_valid;
  wire        ok_msg;
  wire        bus_req;
  wire        wr_desc;

  function is_addr;
    input [11:0] a;
    input [11:0] off;
    begin
      is_addr = (a == off);
    end
  endfunction

  rtpp_sync #(
    .WIDTH (1)
  ) u_mr_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (master_reset_pin),
    .sync_out (mr_sync)
  );

  assign soft_reset_cmd          = ctrl[`RTPP_CTRL_SOFT_RESET];
  assign broadcast_disable       = ctrl[`RTPP_CTRL_BROADCAST_RECEIVED_FLAG_DISABLE];
  assign hold_pointer_on_failure = ctrl[`RTPP_CTRL_HOLD_PTR];
  assign pingpong_enable         = desc[`RTPP_DESC_PP_ENABLE];
  assign pingpong_stop_request   = desc[`RTPP_DESC_STOP_REQ];
  assign force_busy_response     = desc[`RTPP_DESC_FORCE_BUSY];
  assign broadcast_irq_select    = desc[`RTPP_DESC_BROADCAST_RECEIVED_FLAG_IRQ_SEL];
  // The selector only matters in ping-pong mode.
  assign pingpong_mode = pingpong_enable &&
                         (desc[`RTPP_DESC_MODE_LO+MODE_W-1:`RTPP_DESC_MODE_LO] == MODE_PINGPONG); // R6
  // Address 31 is not a valid command when broadcast is disabled.
  assign msg_valid = msg_done && !(broadcast_disable && (msg_rt_addr == `RTPP_BROADCAST_RECEIVED_FLAG_ADDR)); // R9
  assign ok_msg    = !msg_error && !force_busy_response &&
                     !(hold_pointer_on_failure && msg_illegal); // R18
  assign bus_req   = hsel && hready && htrans[1];
  assign wr_desc   = wr_pend && is_addr(wr_addr, `RTPP_OFF_DESC);

  // Compute the full status update so it lands in one write-back.
  always @*
  begin
    next_sel    = desc[`RTPP_DESC_SELECT];
    next_broadcast_received_flag  = desc[`RTPP_DESC_BROADCAST_RECEIVED_FLAG];
    next_ack    = desc[`RTPP_DESC_ACK];
    next_events = {`RTPP_IRQ_WIDTH{1'b0}};
    if (msg_valid)
    begin
      next_events[`RTPP_IRQ_MSG_DONE] = 1'b1;
      if (pingpong_mode && desc[`RTPP_DESC_ACK] && ok_msg)
        next_sel = !desc[`RTPP_DESC_SELECT]; // R3 R17
      if (msg_broadcast && !broadcast_disable)
      begin
        next_broadcast_received_flag = 1'b1; // R7
        if (broadcast_irq_select && ctrl[`RTPP_CTRL_BROADCAST_RECEIVED_FLAG_IRQ_EN])
          next_events[`RTPP_IRQ_BROADCAST_RECEIVED_FLAG] = 1'b1; // R8
      end
    end
    if (pingpong_enable && ctrl[`RTPP_CTRL_ENGINE_EN])
      next_ack = !pingpong_stop_request; // R13 R14 R16
    else
      next_ack = 1'b0; // R12
    if (next_ack != desc[`RTPP_DESC_ACK])
      next_events[`RTPP_IRQ_ACK_CHANGE] = 1'b1;
  end

  // Host view of each register with a write in its data phase already applied.
  always @*
  begin
    next_ctrl = ctrl;
    next_ctrl[`RTPP_CTRL_SOFT_RESET] = 1'b0;
    if (wr_pend && is_addr(wr_addr, `RTPP_OFF_CTRL))
      next_ctrl = hwdata;
    next_irq_mask = irq_mask;
    if (wr_pend && is_addr(wr_addr, `RTPP_OFF_IRQ_MASK))
      next_irq_mask = hwdata[`RTPP_IRQ_WIDTH-1:0];
    next_desc = desc;
    if (wr_desc)
      next_desc = (desc & ~`RTPP_DESC_WMASK) | (hwdata[15:0] & `RTPP_DESC_WMASK); // R11
    next_irq_status = irq_status;
    if (wr_pend && is_addr(wr_addr, `RTPP_OFF_IRQ_STATUS))
      next_irq_status = irq_status & ~hwdata[`RTPP_IRQ_WIDTH-1:0];
    next_irq_status = next_irq_status | next_events;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mr_d <= 1'b0;
    end
    else
    begin
      mr_d <= mr_sync;
    end
  end

  // Address phase capture; read data forwards a write still in its data phase.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= `RTPP_RESET_WORD;
      wr_pend   <= 1'b0;
      wr_addr   <= 12'h000;
    end
    else if (mr_sync || mr_d)
    begin
      wr_pend <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= bus_req && hwrite;
      if (bus_req)
        wr_addr <= haddr[11:0];
      if (bus_req && !hwrite)
      begin
        case (haddr[11:0])
          `RTPP_OFF_CTRL:       hrdata <= next_ctrl;
          `RTPP_OFF_DESC:       hrdata <= {16'h0000, next_desc};
          `RTPP_OFF_STAT:       hrdata <= {29'h0, use_second_pointer, store_enable, state[0]};
          `RTPP_OFF_IRQ_STATUS: hrdata <= {29'h0, next_irq_status};
          `RTPP_OFF_IRQ_MASK:   hrdata <= {29'h0, next_irq_mask};
          default:              hrdata <= `RTPP_RESET_WORD;
        endcase
      end
    end
  end

  // Host registers and the descriptor word; the write-back stage owns the status bits.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl       <= `RTPP_RESET_WORD;
      desc       <= 16'h0000;
      irq_status <= {`RTPP_IRQ_WIDTH{1'b0}};
      irq_mask   <= {`RTPP_IRQ_WIDTH{1'b0}};
      irq        <= 1'b0;
    end
    else if (mr_sync || mr_d)
    begin
      // Master reset clears the whole word and all control.
      ctrl       <= `RTPP_RESET_WORD;
      desc       <= 16'h0000; // R5 R10
      irq_status <= {`RTPP_IRQ_WIDTH{1'b0}};
      irq_mask   <= {`RTPP_IRQ_WIDTH{1'b0}};
      irq        <= 1'b0;
    end
    else
    begin
      ctrl       <= next_ctrl;
      irq_mask   <= next_irq_mask;
      irq_status <= next_irq_status;
      irq        <= |(next_irq_status & next_irq_mask); // R8
      desc       <= next_desc;
      if (state == S_WB)
      begin
        // One write-back carries selector, flag and acknowledge together.
        desc[`RTPP_DESC_SELECT] <= pend_sel; // R19
        desc[`RTPP_DESC_BROADCAST_RECEIVED_FLAG]  <= pend_broadcast_received_flag;
        desc[`RTPP_DESC_ACK]    <= pend_ack; // R13 R14 R16
      end
      if (soft_reset_cmd)
      begin
        desc[`RTPP_DESC_SELECT] <= 1'b0; // R5
        desc[`RTPP_DESC_BROADCAST_RECEIVED_FLAG]  <= 1'b0; // R10
      end
    end
  end

  // Message capture and write-back; a message is taken only in the idle phase.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state              <= S_IDLE;
      pend_sel           <= 1'b0;
      pend_broadcast_received_flag         <= 1'b0;
      pend_ack           <= 1'b0;
      store_enable       <= 1'b0;
      use_second_pointer <= 1'b0;
    end
    else if (mr_sync || mr_d)
    begin
      state              <= S_IDLE;
      pend_sel           <= 1'b0;
      pend_broadcast_received_flag         <= 1'b0;
      pend_ack           <= 1'b0;
      store_enable       <= 1'b0;
      use_second_pointer <= 1'b0;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          pend_sel           <= next_sel;
          pend_broadcast_received_flag         <= next_broadcast_received_flag;
          pend_ack           <= next_ack;
          store_enable       <= msg_valid && !force_busy_response; // R18
          use_second_pointer <= pingpong_mode && desc[`RTPP_DESC_SELECT]; // R1 R2
          state              <= S_WB;
        end
        S_WB:
        begin
          store_enable <= 1'b0;
          state        <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
      if (soft_reset_cmd)
      begin
        // The write-back that follows must not restore the old selector or flag.
        pend_sel   <= 1'b0;
        pend_broadcast_received_flag <= 1'b0;
      end
    end
  end
endmodule // rtpp_core

// >>> rtpp_core_props.sv
// Concurrent checks on the ports of the ping-pong status core.
`timescale 1ns/10ps
module rtpp_core_props (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        master_reset_pin,
  input wire        msg_done,
  input wire        store_enable,
  input wire        use_second_pointer,
  input wire        irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  resp_okay_a: assert property (hresp == 1'b0) else $error("bad response");
  ready_high_a: assert property (hreadyout) else $error("wait state");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite))
    else $error("read data moved");
  store_cause_a: assert property (store_enable |-> $past(msg_done) || $past(msg_done, 2))
    else $error("store without message");
  store_pulse_a: assert property (store_enable |=> !store_enable) else $error("store too long");
  mreset_store_a: assert property (master_reset_pin [*4] |=> !store_enable) else $error("store in reset");
  mreset_sel_a: assert property (master_reset_pin [*4] |=> !use_second_pointer) else $error("select kept");
  mreset_irq_a: assert property (master_reset_pin [*4] |=> !irq) else $error("irq kept");
  cover property (store_enable && use_second_pointer);
  cover property ($rose(irq));
  cover property (master_reset_pin [*4]);
endmodule // rtpp_core_props
bind rtpp_core rtpp_core_props rtpp_core_props_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .master_reset_pin(master_reset_pin), .msg_done(msg_done), .store_enable(store_enable),
  .use_second_pointer(use_second_pointer), .irq(irq));

// >>> rtpp_core_tb.sv
// Self-checking bench for the receive ping-pong status core.
`timescale 1ns/10ps
module rtpp_core_tb;
  localparam [31:0] CT = 32'h0;
  localparam [31:0] DS = 32'h4;
  localparam [31:0] IS = 32'hc;
  localparam [31:0] IM = 32'h10;
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         master_reset_pin = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg  [31:0] r;
  reg  [95:0] rows [0:3];
  wire [31:0] hrdata;
  wire        hreadyout, hresp, store_enable, use_second_pointer, irq;
  wire        msg_done, msg_error, msg_illegal, msg_broadcast;
  wire [4:0]  msg_rt_addr;
  integer     n_fail = 0;
  integer     samples_checked = 0;
  integer     i;
  always #5 hclk = ~hclk;
  rtpp_core rtpp_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .master_reset_pin(master_reset_pin), .msg_done(msg_done), .msg_error(msg_error),
    .msg_illegal(msg_illegal), .msg_broadcast(msg_broadcast), .msg_rt_addr(msg_rt_addr),
    .store_enable(store_enable), .use_second_pointer(use_second_pointer), .irq(irq));
  rtpp_bc_model rtpp_bc_model_inst (.hclk(hclk), .store_enable(store_enable),
    .use_second_pointer(use_second_pointer), .msg_done(msg_done), .msg_error(msg_error),
    .msg_illegal(msg_illegal), .msg_broadcast(msg_broadcast), .msg_rt_addr(msg_rt_addr));
  task check(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [31:0] a, input [31:0] d);
    begin
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
    end
  endtask
  task rd(input [31:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      check(r, e);
    end
  endtask
  task msg(input e, input il, input b, input [4:0] a, input st, input sc);
    begin
      rtpp_bc_model_inst.send(e, il, b, a);
      check({30'h0, rtpp_bc_model_inst.stored, rtpp_bc_model_inst.second}, {30'h0, st, sc});
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial
  begin
    #100000;
    n_fail = n_fail + 1;
    complete_run;
  end
  initial
  begin
    rows[0] = {CT, 32'h1c, 32'h1c};
    rows[1] = {IM, 32'h7, 32'h7};
    rows[2] = {32'h20, 32'hffff, 32'h0};
    rows[3] = {DS, 32'hffff, 32'hf0ff};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(DS, 32'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
      bus(1'b1, rows[i][95:64], rows[i][63:32]);
      rd(rows[i][95:64], rows[i][31:0]);
    end
    bus(1'b1, DS, 32'h2005);
    repeat (4) @(posedge hclk);
    rd(DS, 32'h2105);
    msg(1'b0, 1'b0, 1'b0, 5'h01, 1'b1, 1'b0);
    rd(DS, 32'h2505);
    msg(1'b0, 1'b0, 1'b0, 5'h01, 1'b1, 1'b1);
    rd(DS, 32'h2105);
    msg(1'b0, 1'b1, 1'b0, 5'h01, 1'b1, 1'b0);
    rd(DS, 32'h2105);
    msg(1'b1, 1'b0, 1'b0, 5'h01, 1'b1, 1'b0);
    rd(DS, 32'h2105);
    msg(1'b0, 1'b0, 1'b1, 5'h1f, 1'b1, 1'b0);
    rd(DS, 32'h2705);
    rd(IS, 32'h7);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, IM, 32'h0);
    repeat (4) @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, IS, 32'h7);
    bus(1'b1, IM, 32'h7);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, CT, 32'h1d);
    repeat (4) @(posedge hclk);
    rd(DS, 32'h2105);
    bus(1'b1, DS, 32'h200d);
    repeat (4) @(posedge hclk);
    rd(DS, 32'h200d);
    msg(1'b0, 1'b0, 1'b0, 5'h01, 1'b1, 1'b0);
    rd(DS, 32'h200d);
    bus(1'b1, DS, 32'h2005);
    repeat (4) @(posedge hclk);
    rd(DS, 32'h2105);
    bus(1'b1, DS, 32'h3005);
    msg(1'b0, 1'b0, 1'b0, 5'h01, 1'b0, 1'b0);
    rd(DS, 32'h3105);
    bus(1'b1, CT, 32'h1e);
    bus(1'b1, DS, 32'h2005);
    msg(1'b0, 1'b0, 1'b1, 5'h1f, 1'b0, 1'b0);
    rd(DS, 32'h2105);
    bus(1'b1, DS, 32'h2006);
    msg(1'b0, 1'b0, 1'b0, 5'h01, 1'b1, 1'b0);
    rd(DS, 32'h2106);
    master_reset_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    master_reset_pin <= 1'b0;
    repeat (4) @(posedge hclk);
    rd(DS, 32'h0);
    rd(CT, 32'h0);
    complete_run;
  end
endmodule // rtpp_core_tb

// >>> rtpp_regs.vh
// Register offsets, field positions and reset values of the receive ping-pong status block.
`ifndef RTPP_REGS_VH
`define RTPP_REGS_VH
`define RTPP_OFF_CTRL        12'h000
`define RTPP_OFF_DESC        12'h004
`define RTPP_OFF_STAT        12'h008
`define RTPP_OFF_IRQ_STATUS  12'h00c
`define RTPP_OFF_IRQ_MASK    12'h010
`define RTPP_CTRL_SOFT_RESET     0
`define RTPP_CTRL_BROADCAST_RECEIVED_FLAG_DISABLE  1
`define RTPP_CTRL_HOLD_PTR       2
`define RTPP_CTRL_BROADCAST_RECEIVED_FLAG_IRQ_EN   3
`define RTPP_CTRL_ENGINE_EN      4
`define RTPP_DESC_PP_ENABLE      2
`define RTPP_DESC_STOP_REQ       3
`define RTPP_DESC_ACK            8
`define RTPP_DESC_BROADCAST_RECEIVED_FLAG          9
`define RTPP_DESC_SELECT         10
`define RTPP_DESC_FORCE_BUSY     12
`define RTPP_DESC_BROADCAST_RECEIVED_FLAG_IRQ_SEL  13
`define RTPP_DESC_MODE_LO        0
`define RTPP_DESC_WMASK          16'hf0ff
`define RTPP_IRQ_MSG_DONE        0
`define RTPP_IRQ_BROADCAST_RECEIVED_FLAG           1
`define RTPP_IRQ_ACK_CHANGE      2
`define RTPP_IRQ_WIDTH           3
`define RTPP_RESET_WORD          32'h00000000
`define RTPP_BROADCAST_RECEIVED_FLAG_ADDR          5'h1f
`endif

// >>> rtpp_sync.v
// Two-flop synchroniser for a vector of asynchronous inputs.
`timescale 1ns/10ps
module rtpp_sync #(
  parameter WIDTH = 1
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage1   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // rtpp_sync
